// *** rtl/sgg_defs.vh ***
/*
 * constants for the sweep gate generator: register offsets, field
 * positions, reset values and time counts.
 * assumes a 250 MHz pclk; every time setting is held in ticks of
 * four clocks (16 ns) so that 40 s still fits a 32-bit register.
 */
`ifndef SGG_DEFS_VH
`define SGG_DEFS_VH

// ==========================================================
// clock and time base
// ==========================================================
`define SGG_CLK_MHZ 250
`define SGG_TICK_CYC 4
// time settings in microseconds, converted to ticks
`define SGG_DLY_DEF_US 1000
`define SGG_LEN_DEF_US 5000
`define SGG_HLD_DEF_US 100000
`define SGG_PER_DEF_US 100000
`define SGG_OFS_DEF_US 100000
`define SGG_DLY_DEF ((`SGG_DLY_DEF_US*`SGG_CLK_MHZ)/`SGG_TICK_CYC)
`define SGG_LEN_DEF ((`SGG_LEN_DEF_US*`SGG_CLK_MHZ)/`SGG_TICK_CYC)
`define SGG_HLD_DEF ((`SGG_HLD_DEF_US*`SGG_CLK_MHZ)/`SGG_TICK_CYC)
`define SGG_PER_DEF ((`SGG_PER_DEF_US*`SGG_CLK_MHZ)/`SGG_TICK_CYC)
`define SGG_OFS_DEF ((`SGG_OFS_DEF_US*`SGG_CLK_MHZ)/`SGG_TICK_CYC)
// limits in ticks: delay 0..40 s, length 100 us..5 s
`define SGG_DLY_MIN 32'h0000_0000
`define SGG_DLY_MAX 32'h9502_F900
`define SGG_LEN_MIN 32'h0000_186A
`define SGG_LEN_MAX 32'h12A0_5F20
// period 100 ns..20 s (rounded up), offset 10 ns..20 s
`define SGG_PER_MIN 32'h0000_0007
`define SGG_PER_MAX 32'h4A81_7C80
`define SGG_OFS_MIN 32'h0000_0001
`define SGG_HLD_MAX 32'hFFFF_FFFF

// ==========================================================
// thresholds: millivolts and hundredths of dBm, signed 16 bit
// ==========================================================
`define SGG_THR_DEF 16'h04B0
`define SGG_THR_MIN 16'hEC78
`define SGG_THR_MAX 16'h1388
`define SGG_BTH_DEF 16'hF830
`define SGG_BTH_MIN 16'h9688
`define SGG_BTH_MAX 16'h0BB8

// ==========================================================
// register byte offsets
// ==========================================================
`define SGG_REG_CTRL 8'h00
`define SGG_REG_DELAY 8'h04
`define SGG_REG_LENGTH 8'h08
`define SGG_REG_HOLDOFF 8'h0C
`define SGG_REG_PERIOD 8'h10
`define SGG_REG_OFFSET 8'h14
`define SGG_REG_THR_A 8'h18
`define SGG_REG_THR_B 8'h1C
`define SGG_REG_BURST_THR 8'h20
`define SGG_REG_STATUS 8'h24

// ==========================================================
// control fields
// ==========================================================
`define SGG_CTL_LEVEL 0
`define SGG_CTL_MANHLD 1
`define SGG_CTL_SRC_LO 2
`define SGG_CTL_SRC_HI 4
`define SGG_CTL_POL_LO 5
`define SGG_CTL_POL_HI 9
`define SGG_CTL_SYN_LO 10
`define SGG_CTL_SYN_HI 11
`define SGG_SRC_LAST 3'h4

`endif

// *** rtl/sgg_gate.v ***
/*
 * sweep gate generator: decides when the measurement path passes
 * signal. edge and level control, delay, length, holdoff, five
 * trigger sources with polarity, a periodic timer with optional sync.
 * assumes an apb master on pclk, trigger pins from comparators in
 * another domain, and a same-clock sweep reset-done level.
 */
// The register addresses and the APB slave port were chosen for this implementation.
// Functional notes
// - edge mode starts on selected polarity edge
// - gate stays closed for the full delay
// - gate opens exactly length, then blocks
// - level mode follows active level per polarity
// - level mode ignores delay and length
// - holdoff wait after each gate event
// - manual holdoff timed, else wait sweep reset
// - holdoff applies for every gating method
// - reset: holdoff 100 ms, manual holdoff off
// - one of five trigger sources selected
// - per-source polarity, positive after reset
// - external thresholds -5..5 V, default 1.2 V
// - burst threshold kept, default -20 dBm
// - timer sync off, aux a, aux b, burst
// - delay 0..40 s, default 1 ms
// - length 100 us..5 s, default 5 ms
// - timer period 100 ns..20 s
// - offset 10 ns..20 s, never above period
`timescale 1ns/1ps
`include "sgg_defs.vh"

module sgg_gate #(
   parameter [31:0] DLY_DEF = `SGG_DLY_DEF,
   parameter [31:0] LEN_DEF = `SGG_LEN_DEF,
   parameter [31:0] HLD_DEF = `SGG_HLD_DEF,
   parameter [31:0] PER_DEF = `SGG_PER_DEF,
   parameter [31:0] OFS_DEF = `SGG_OFS_DEF
) (
   // clock, reset, enable
   input wire pclk,
   input wire presetn,
   input wire ce,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // trigger pins from comparators and detector
   input wire line_trig,
   input wire aux_trigger_input_a,
   input wire aux_trigger_input_b,
   input wire burst_power_source,
   // sweep side
   input wire sweep_reset_done,
   output reg gate_enable_q,
   // thresholds forwarded to the analogue side
   output reg [15:0] thr_a_q,
   output reg [15:0] thr_b_q,
   output reg [15:0] burst_thr_q
);

   // gate state machine codes
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_DLY = 4'b0010;
   localparam [3:0] ST_OPEN = 4'b0100;
   localparam [3:0] ST_HOLD = 4'b1000;
   localparam [33:0] ONE34 = 34'h0_0000_0001;

   // ==========================================================
   // settings
   // ==========================================================
   reg level_q; // 1 = level control
   reg man_hld_q; // 1 = programmed holdoff
   reg [2:0] src_q; // gate source select
   reg [4:0] pol_q; // 1 = negative, per source
   reg [1:0] syn_q; // timer sync select
   reg [31:0] dly_q;
   reg [31:0] len_q;
   reg [31:0] hld_q;
   reg [31:0] per_q;
   reg [31:0] ofs_q;

   // dedicated down-counters, in clocks
   reg [33:0] dly_cnt_q;
   reg [33:0] len_cnt_q;
   reg [33:0] hld_cnt_q;
   reg [33:0] per_cnt_q;
   reg [33:0] ofs_cnt_q;
   reg ofs_run_q; // waiting out offset after sync
   reg fire_q; // timer trigger pulse
   reg [3:0] st_q;

   // pin synchronisers and edge history
   reg [3:0] pin_s1_q;
   reg [3:0] pin_s2_q;
   reg src_prev_q;
   reg syn_prev_q;

   // ==========================================================
   // clamp helpers
   // ==========================================================
   function [31:0] clampu;
      input [31:0] v;
      input [31:0] lo;
      input [31:0] hi;
      begin
         if (v < lo)
            clampu = lo;
         else if (v > hi)
            clampu = hi;
         else
            clampu = v;
      end
   endfunction

   function [15:0] clamps;
      input [15:0] v;
      input [15:0] lo;
      input [15:0] hi;
      begin
         if ($signed(v) < $signed(lo))
            clamps = lo;
         else if ($signed(v) > $signed(hi))
            clamps = hi;
         else
            clamps = v;
      end
   endfunction

   // ==========================================================
   // source selection and qualification
   // ==========================================================
   wire [4:0] src_raw = {fire_q, pin_s2_q};
   wire [4:0] src_lvl_v = src_raw ^ pol_q;
   reg src_lvl;
   reg syn_lvl;

   // pick the one active source, polarity applied
   always @*
   begin
      src_lvl = 1'b0;
      if (src_q <= `SGG_SRC_LAST)
         src_lvl = src_lvl_v[src_q];
      syn_lvl = 1'b0;
      if (syn_q != 2'b00)
         syn_lvl = src_lvl_v[syn_q];
   end

   wire src_edge = src_lvl & ~src_prev_q;
   wire syn_evt = syn_lvl & ~syn_prev_q & (syn_q != 2'b00);

   // ==========================================================
   // apb decode and register file
   // ==========================================================
   wire acc = psel & penable;
   wire wr_en = acc & pwrite & pready;
   reg [31:0] rd_mux;
   reg rd_err;

   // read data and unmapped detection
   always @*
   begin
      rd_mux = 32'h0000_0000;
      rd_err = 1'b0;
      if (paddr == `SGG_REG_CTRL)
         rd_mux = {20'h0_0000, syn_q, pol_q, src_q, man_hld_q, level_q};
      else if (paddr == `SGG_REG_DELAY)
         rd_mux = dly_q;
      else if (paddr == `SGG_REG_LENGTH)
         rd_mux = len_q;
      else if (paddr == `SGG_REG_HOLDOFF)
         rd_mux = hld_q;
      else if (paddr == `SGG_REG_PERIOD)
         rd_mux = per_q;
      else if (paddr == `SGG_REG_OFFSET)
         rd_mux = ofs_q;
      else if (paddr == `SGG_REG_THR_A)
         rd_mux = {16'h0000, thr_a_q};
      else if (paddr == `SGG_REG_THR_B)
         rd_mux = {16'h0000, thr_b_q};
      else if (paddr == `SGG_REG_BURST_THR)
         rd_mux = {16'h0000, burst_thr_q};
      else if (paddr == `SGG_REG_STATUS)
         rd_mux = {26'h000_0000, ofs_run_q, st_q, gate_enable_q};
      else
         rd_err = 1'b1;
   end

   // bus answer one cycle into the access phase, then settings
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         level_q <= 1'b0;
         man_hld_q <= 1'b0;
         src_q <= 3'h0;
         pol_q <= 5'h00;
         syn_q <= 2'h0;
         dly_q <= DLY_DEF;
         len_q <= LEN_DEF;
         hld_q <= HLD_DEF;
         per_q <= PER_DEF;
         ofs_q <= OFS_DEF;
         thr_a_q <= `SGG_THR_DEF;
         thr_b_q <= `SGG_THR_DEF;
         burst_thr_q <= `SGG_BTH_DEF;
      end
      else if (ce)
      begin
         pready <= acc & ~pready;
         if (acc & ~pready)
         begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= rd_err;
         end
         if (wr_en & ~rd_err)
         begin
            if (paddr == `SGG_REG_CTRL)
            begin
               level_q <= pwdata[`SGG_CTL_LEVEL];
               man_hld_q <= pwdata[`SGG_CTL_MANHLD];
               // out-of-range source codes keep the old choice
               if (pwdata[`SGG_CTL_SRC_HI:`SGG_CTL_SRC_LO] <= `SGG_SRC_LAST)
                  src_q <= pwdata[`SGG_CTL_SRC_HI:`SGG_CTL_SRC_LO];
               pol_q <= pwdata[`SGG_CTL_POL_HI:`SGG_CTL_POL_LO];
               syn_q <= pwdata[`SGG_CTL_SYN_HI:`SGG_CTL_SYN_LO];
            end
            else if (paddr == `SGG_REG_DELAY)
               dly_q <= clampu(pwdata, `SGG_DLY_MIN, `SGG_DLY_MAX);
            else if (paddr == `SGG_REG_LENGTH)
               len_q <= clampu(pwdata, `SGG_LEN_MIN, `SGG_LEN_MAX);
            else if (paddr == `SGG_REG_HOLDOFF)
               hld_q <= pwdata;
            else if (paddr == `SGG_REG_PERIOD)
            begin
               per_q <= clampu(pwdata, `SGG_PER_MIN, `SGG_PER_MAX);
               // a shorter period drags the offset down with it
               if (ofs_q > clampu(pwdata, `SGG_PER_MIN, `SGG_PER_MAX))
                  ofs_q <= clampu(pwdata, `SGG_PER_MIN, `SGG_PER_MAX);
            end
            else if (paddr == `SGG_REG_OFFSET)
               ofs_q <= clampu(pwdata, `SGG_OFS_MIN, per_q);
            else if (paddr == `SGG_REG_THR_A)
               thr_a_q <= clamps(pwdata[15:0], `SGG_THR_MIN,
                                 `SGG_THR_MAX);
            else if (paddr == `SGG_REG_THR_B)
               thr_b_q <= clamps(pwdata[15:0], `SGG_THR_MIN,
                                 `SGG_THR_MAX);
            else if (paddr == `SGG_REG_BURST_THR)
               burst_thr_q <= clamps(pwdata[15:0], `SGG_BTH_MIN,
                                     `SGG_BTH_MAX);
         end
      end
   end

   // ==========================================================
   // pin synchronisers
   // ==========================================================
   // two flops per comparator pin; only stage two is read
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_s1_q <= 4'h0;
         pin_s2_q <= 4'h0;
      end
      else if (ce)
      begin
         pin_s1_q <= {burst_power_source, aux_trigger_input_b,
                      aux_trigger_input_a, line_trig};
         pin_s2_q <= pin_s1_q;
      end
   end

   // ==========================================================
   // periodic timer source
   // ==========================================================
   // free-runs on the period; a sync event restarts it via offset
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         per_cnt_q <= {PER_DEF, 2'b00};
         ofs_cnt_q <= {OFS_DEF, 2'b00};
         ofs_run_q <= 1'b0;
         fire_q <= 1'b0;
         syn_prev_q <= 1'b0;
      end
      else if (ce)
      begin
         syn_prev_q <= syn_lvl;
         fire_q <= 1'b0;
         if (syn_evt)
         begin
            ofs_cnt_q <= {ofs_q, 2'b00};
            ofs_run_q <= 1'b1;
         end
         else if (ofs_run_q)
         begin
            // first trigger lands one offset after the sync edge
            if (ofs_cnt_q <= ONE34)
            begin
               ofs_run_q <= 1'b0;
               fire_q <= 1'b1;
               per_cnt_q <= {per_q, 2'b00};
            end
            else
               ofs_cnt_q <= ofs_cnt_q - ONE34;
         end
         else if (per_cnt_q <= ONE34)
         begin
            fire_q <= 1'b1;
            per_cnt_q <= {per_q, 2'b00};
         end
         else
            per_cnt_q <= per_cnt_q - ONE34;
      end
   end

   // ==========================================================
   // gate state machine
   // ==========================================================
   // idle accepts triggers; delay and holdoff ignore them, open ignores them in edge mode only
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q <= ST_IDLE;
         gate_enable_q <= 1'b0;
         src_prev_q <= 1'b0;
         dly_cnt_q <= 34'h0_0000_0000;
         len_cnt_q <= 34'h0_0000_0000;
         hld_cnt_q <= 34'h0_0000_0000;
      end
      else if (ce)
      begin
         src_prev_q <= src_lvl;
         case (st_q)
            ST_IDLE:
               if (level_q)
               begin
                  if (src_lvl)
                  begin
                     st_q <= ST_OPEN;
                     gate_enable_q <= 1'b1;
                  end
               end
               else if (src_edge)
               begin
                  if (dly_q == 32'h0000_0000)
                  begin
                     st_q <= ST_OPEN;
                     gate_enable_q <= 1'b1;
                     len_cnt_q <= {len_q, 2'b00};
                  end
                  else
                  begin
                     st_q <= ST_DLY;
                     dly_cnt_q <= {dly_q, 2'b00};
                  end
               end
            ST_DLY:
               if (level_q)
                  st_q <= ST_IDLE;
               else if (dly_cnt_q <= ONE34)
               begin
                  st_q <= ST_OPEN;
                  gate_enable_q <= 1'b1;
                  len_cnt_q <= {len_q, 2'b00};
               end
               else
                  dly_cnt_q <= dly_cnt_q - ONE34;
            ST_OPEN:
               if (level_q)
               begin
                  // level mode: only the qualified level matters
                  if (!src_lvl)
                  begin
                     st_q <= ST_HOLD;
                     gate_enable_q <= 1'b0;
                     hld_cnt_q <= {hld_q, 2'b00};
                  end
               end
               else if (len_cnt_q <= ONE34)
               begin
                  st_q <= ST_HOLD;
                  gate_enable_q <= 1'b0;
                  hld_cnt_q <= {hld_q, 2'b00};
               end
               else
                  len_cnt_q <= len_cnt_q - ONE34;
            ST_HOLD:
               // same wait whatever the downstream gating method
               if (man_hld_q)
               begin
                  if (hld_cnt_q <= ONE34)
                     st_q <= ST_IDLE;
                  else
                     hld_cnt_q <= hld_cnt_q - ONE34;
               end
               else if (sweep_reset_done)
                  st_q <= ST_IDLE;
            default:
            begin
               st_q <= ST_IDLE;
               gate_enable_q <= 1'b0;
            end
         endcase
      end
   end

endmodule

// *** sim/sgg_gate_sva.sv ***
/* checker for sgg_gate: apb timing, edge gate length, holdoff gap.
   assumes only the top ports and the design's LEN_DEF. */
`timescale 1ns/1ps
module sgg_gate_sva #(
   parameter [31:0] LEN_DEF = 32'h0000_000A
) (
   // clock, reset, enable
   input wire pclk,
   input wire presetn,
   input wire ce,
   // apb
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // gate and threshold
   input wire gate_enable_q,
   input wire [15:0] thr_a_q
);
   // ==========================================
   // shadow of mode and length, high-time count
   // ==========================================
   reg lvl_q; // level mode written
   reg [33:0] len_q; // length in ticks
   reg [33:0] hi_q; // cycles gate has been high
   reg [33:0] len_open_q; // length in force as the gate opened
   wire wr_ok = pready && pwrite && !pslverr;
   // follow writes, count the open time
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lvl_q <= 1'b0;
         len_q <= {2'b00, LEN_DEF};
         hi_q <= 34'h0;
         len_open_q <= {2'b00, LEN_DEF};
      end
      else if (ce)
      begin
         if (wr_ok && paddr == 8'h00)
            lvl_q <= pwdata[0];
         if (wr_ok && paddr == 8'h08)
            len_q <= (pwdata < 32'h0000_186A) ? 34'h186A : {2'b00, pwdata};
         hi_q <= gate_enable_q ? hi_q + 34'h1 : 34'h0;
         // the length counter is loaded as the gate rises
         if (!gate_enable_q)
            len_open_q <= len_q;
      end
   end
   // ==========================================
   // properties
   // ==========================================
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_acc_start;
      psel && $rose(penable) && ce;
   endsequence
   a_pready_wait: assert property (s_acc_start |-> !pready ##1 (pready || !ce))
      else $error("pready not in second access cycle");
   a_pready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_slverr_map: assert property (pready && paddr[1:0] == 2'b00
      |-> pslverr == (paddr > 8'h24)) else $error("pslverr wrong for address");
   a_write_rdzero: assert property (pready && pwrite |-> prdata == 32'h0)
      else $error("prdata not zero on write");
   a_thr_cause: assert property ($changed(thr_a_q) |->
      $past(wr_ok && paddr == 8'h18)) else $error("threshold moved alone");
   a_edge_length: assert property ($fell(gate_enable_q) && !lvl_q
      |-> hi_q == len_open_q * 4) else $error("gate open time wrong");
   a_hold_gap: assert property ($fell(gate_enable_q)
      |-> !gate_enable_q [*2]) else $error("gate reopened at once");
   a_reset_closed: assert property ($rose(presetn)
      |-> !gate_enable_q && !pready) else $error("gate open after reset");
   a_ce_freeze: assert property (!ce |=> $stable(gate_enable_q))
      else $error("gate moved while frozen");
endmodule
bind sgg_gate sgg_gate_sva #(.LEN_DEF(LEN_DEF)) u_sva (.pclk(pclk),
   .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .gate_enable_q(gate_enable_q),
   .thr_a_q(thr_a_q));

// *** sim/sgg_gate_test.sv ***
/* bench for sgg_gate: registers, edge and level gating, holdoff,
   sources, timer period, second reset. assumes small count defaults. */
`timescale 1ns/1ps
module sgg_gate_test;
   // ==========================================
   // signals
   // ==========================================
   localparam [31:0] DLY = 32'h0000_0003;
   localparam [31:0] LEN = 32'h0000_000A;
   localparam [31:0] HLD = 32'h0000_0014;
   localparam [31:0] PER = 32'h0000_0032;
   reg pclk;
   reg presetn;
   reg ce;
   reg psel;
   reg penable;
   reg pwrite;
   reg [7:0] paddr;
   reg [31:0] pwdata;
   reg [31:0] rd;
   reg er;
   wire [31:0] prdata;
   wire pready;
   wire pslverr;
   wire gate;
   wire pl;
   wire pa;
   wire pb;
   wire pr;
   wire done;
   wire [15:0] thr_a;
   wire [15:0] thr_b;
   wire [15:0] thr_r;
   integer err_total, compares, cyc, n, a, i;
   integer tm [0:2];
   reg [31:0] dd [0:2];
   reg [31:0] ex [0:3];
   sgg_gate #(.DLY_DEF(DLY), .LEN_DEF(LEN), .HLD_DEF(HLD), .PER_DEF(PER),
      .OFS_DEF(32'h0000_001E)) dut (.pclk(pclk), .presetn(presetn),
      .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .line_trig(pl), .aux_trigger_input_a(pa),
      .aux_trigger_input_b(pb), .burst_power_source(pr),
      .sweep_reset_done(done), .gate_enable_q(gate), .thr_a_q(thr_a),
      .thr_b_q(thr_b), .burst_thr_q(thr_r));
   sgg_trig_model m (.pclk(pclk), .presetn(presetn), .gate_enable_q(gate),
      .line_trig(pl), .aux_trigger_input_a(pa), .aux_trigger_input_b(pb),
      .burst_power_source(pr), .sweep_reset_done(done));
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // hang guard
   always @(posedge pclk)
   begin
      cyc = cyc + 1;
      if (cyc == 40000)
      begin
         err_total = err_total + 1;
         end_of_test;
      end
   end
   // ==========================================
   // tasks
   // ==========================================
   task chk(input [31:0] g, input [31:0] e);
   begin
      compares = compares + 1;
      if (g !== e)
      begin
         err_total = err_total + 1;
         $display("MISMATCH at %0t got %h expected %h", $time, g, e);
      end
   end
   endtask
   // one apb transfer, result in rd and er
   task apb(input w, input [7:0] ad, input [31:0] d);
      integer k;
   begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 20)
      begin
         @(posedge pclk);
         k = k + 1;
      end
      chk(k < 20, 1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask
   // cycles until the gate shows v
   task wg(input v, output integer c);
   begin
      c = 0;
      while (gate !== v && c < 3000)
      begin
         @(posedge pclk);
         c = c + 1;
      end
   end
   endtask
   // gate must hold v for c cycles
   task stay(input v, input integer c);
      integer j, bad;
   begin
      bad = 0;
      for (j = 0; j < c; j = j + 1)
      begin
         @(posedge pclk);
         if (gate !== v)
            bad = 1;
      end
      chk(bad, 0);
   end
   endtask
   task end_of_test;
   begin
      if (err_total == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   end
   endtask
   // ==========================================
   // main sequence
   // ==========================================
   initial
   begin
      cyc = 0; err_total = 0; compares = 0;
      presetn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0;
      pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
      dd[0] = 32'h0; dd[1] = DLY; dd[2] = 32'h0000_0005;
      ex[0] = 32'h0; ex[1] = DLY; ex[2] = LEN; ex[3] = HLD;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 4; i = i + 1)
      begin
         apb(0, 8'(i * 4), 32'h0);
         chk(rd, ex[i]);
      end
      chk(thr_a, 16'h04B0);
      chk(thr_r, 16'hF830);
      // edge mode, manual holdoff, three delays
      apb(1, 8'h00, 32'h0000_0002);
      for (i = 0; i < 3; i = i + 1)
      begin
         apb(1, 8'h04, dd[i]);
         m.set_pins(4'h1);
         wg(1, tm[i]);
         wg(0, n);
         chk(n, LEN * 4);
         m.set_pins(4'h0);
         repeat (8) @(posedge pclk);
         m.set_pins(4'h1);
         stay(0, 150);
         m.set_pins(4'h0);
         repeat (10) @(posedge pclk);
         chk(tm[i] - tm[0], dd[i] * 4);
      end
      // negative polarity starts on the falling pin
      m.set_pins(4'h1);
      wg(1, n);
      wg(0, n);
      repeat (100) @(posedge pclk);
      apb(1, 8'h00, 32'h0000_0022);
      stay(0, 40);
      m.set_pins(4'h0);
      wg(1, n);
      chk(n < 60, 1);
      wg(0, n);
      repeat (100) @(posedge pclk);
      // each pin source, others must not trigger
      for (i = 0; i < 4; i = i + 1)
      begin
         apb(1, 8'h00, 32'h0000_0002 | (i << 2));
         m.set_pins(~(4'h1 << i));
         stay(0, 40);
         m.set_pins(4'hF);
         wg(1, n);
         chk(n < 60, 1);
         wg(0, n);
         m.set_pins(4'h0);
         repeat (100) @(posedge pclk);
      end
      // auto holdoff waits for the sweep reset flag
      apb(1, 8'h00, 32'h0000_0000);
      m.set_pins(4'h1);
      wg(1, n);
      wg(0, n);
      m.set_pins(4'h0);
      repeat (20) @(posedge pclk);
      m.set_pins(4'h1);
      stay(0, 200);
      m.set_pins(4'h0);
      repeat (150) @(posedge pclk);
      m.set_pins(4'h1);
      wg(1, n);
      chk(n < 60, 1);
      wg(0, n);
      m.set_pins(4'h0);
      repeat (320) @(posedge pclk);
      // level mode ignores a long delay and the length
      apb(1, 8'h04, 32'h0000_1388);
      apb(1, 8'h00, 32'h0000_0003);
      m.set_pins(4'h1);
      wg(1, n);
      chk(n < 20, 1);
      stay(1, 100);
      m.set_pins(4'h0);
      wg(0, n);
      chk(n < 20, 1);
      repeat (100) @(posedge pclk);
      apb(1, 8'h00, 32'h0000_0023);
      wg(1, n);
      chk(n < 20, 1);
      m.set_pins(4'h1);
      wg(0, n);
      chk(n < 20, 1);
      // timer source, one gate per period
      apb(1, 8'h04, DLY);
      apb(1, 8'h10, PER);
      apb(1, 8'h00, 32'h0000_0012);
      wg(1, n);
      wg(0, a);
      wg(1, n);
      chk(a + n, PER * 4);
      ce <= 1'b0;
      repeat (8) @(posedge pclk);
      ce <= 1'b1;
      // sync on aux a: first pulse one offset after its edge
      apb(1, 8'h00, 32'h0000_0412);
      wg(0, n);
      m.set_pins(4'h3);
      wg(1, n);
      chk(n, 32'h0000_001E * 4 + DLY * 4 + 5);
      // limits, sync codes, unmapped place
      apb(1, 8'h00, 32'h0000_0000);
      apb(1, 8'h04, 32'hFFFF_FFFF);
      apb(0, 8'h04, 32'h0);
      chk(rd, 32'h9502_F900);
      apb(1, 8'h08, 32'h0000_0001);
      apb(0, 8'h08, 32'h0);
      chk(rd, 32'h0000_186A);
      apb(1, 8'h10, 32'h0000_0001);
      apb(0, 8'h10, 32'h0);
      chk(rd, 32'h0000_0007);
      apb(1, 8'h14, 32'h0000_0100);
      apb(0, 8'h14, 32'h0);
      chk(rd, 32'h0000_0007);
      apb(1, 8'h18, 32'h0000_7FFF);
      @(posedge pclk);
      chk(thr_a, 16'h1388);
      apb(1, 8'h1C, 32'hFFFF_8000);
      @(posedge pclk);
      chk(thr_b, 16'hEC78);
      apb(1, 8'h20, 32'hFFFF_8000);
      @(posedge pclk);
      chk(thr_r, 16'h9688);
      for (i = 0; i < 4; i = i + 1)
      begin
         apb(1, 8'h00, i << 10);
         apb(0, 8'h00, 32'h0);
         chk(rd, i << 10);
      end
      apb(0, 8'h28, 32'h0);
      chk(er, 1'b1);
      // second reset restores the settings
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, 8'h08, 32'h0);
      chk(rd, LEN);
      apb(0, 8'h00, 32'h0);
      chk(rd, 32'h0);
      chk(thr_a, 16'h04B0);
      end_of_test;
   end
endmodule

// *** sim/sgg_trig_model.sv ***
/* partner model: comparator and detector results, sweep reset flag.
   assumes the bench moves pins through set_pins after a clock edge. */
`timescale 1ns/1ps
module sgg_trig_model #(
   parameter integer RST_CYC = 300
) (
   // clock, reset, gate seen by the sweep
   input wire pclk,
   input wire presetn,
   input wire gate_enable_q,
   // digital comparator and detector results
   output wire line_trig,
   output wire aux_trigger_input_a,
   output wire aux_trigger_input_b,
   output wire burst_power_source,
   // sweep reset state complete
   output reg sweep_reset_done
);
   reg [3:0] pins_q = 4'h0; // comparator outputs
   integer cnt_q; // cycles since the gate closed
   assign {burst_power_source, aux_trigger_input_b} = pins_q[3:2];
   assign {aux_trigger_input_a, line_trig} = pins_q[1:0];
   // bench sets the digital results
   task set_pins(input [3:0] v);
      pins_q <= v;
   endtask
   // sweep reset completes a while after the gate closes
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn || gate_enable_q)
      begin
         cnt_q <= 0;
         sweep_reset_done <= 1'b0;
      end
      else if (cnt_q < RST_CYC)
         cnt_q <= cnt_q + 1;
      else
         sweep_reset_done <= 1'b1;
   end
endmodule
